// [rtl/tos_pkg.sv]
package tos_pkg;
  // timing
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          TICK_PERIOD_NS = 1000;
  localparam int          US_CYCLES      = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PRE_W          = 6;
  localparam int          TICKER_W       = 32;
  // output area layout
  localparam int          ENTRIES_SMALL  = 5;
  localparam int          ENTRIES_LARGE  = 15;
  localparam int          ENTRY_W        = 32;
  localparam int          STATE_LSB      = 0;
  localparam int          SEQ_LSB        = 8;
  localparam int          TIME_LSB       = 16;
  localparam int          TIME_W         = 16;
  localparam int          SEQ_W          = 6;
  localparam int          SEQ_END_BIT    = 6;
  localparam int          CH_FIRST_BIT   = 4;
  localparam int          CHANNELS       = 4;
  localparam int          FIFO_DEPTH     = 16;
  // input area byte offsets
  localparam int          OFS_LAST_SEQ   = 0;
  localparam int          OFS_NEXT_SEQ   = 1;
  localparam int          OFS_QSTATE     = 2;
  localparam int          OFS_QCOUNT     = 3;
  // fixed marker bits 7:6
  localparam logic [1:0]  LAST_MARK      = 2'h1;
  localparam logic [1:0]  NEXT_MARK      = 2'h3;
  // queue state codes
  localparam logic [1:0]  QS_OK          = 2'h0;
  localparam logic [1:0]  QS_NO_FOLLOW   = 2'h1;
  localparam logic [1:0]  QS_EMPTY       = 2'h2;
  localparam logic [1:0]  QS_FULL        = 2'h3;
  localparam logic [5:0]  QS_PAD         = 6'h00;
  localparam logic [5:0]  SEQ_RESET      = 6'h00;
endpackage

// [rtl/tos_scheduler.sv]
`timescale 1ns/100ps
// How it works
// RQ1: entry keeps time, output state, sequence
// RQ2: area holds 5 or 15 entries
// RQ3: full queue refuses further entries
// RQ4: host checks queue state before writing; tos_host_model send writes without reading it
// RQ5: byte 0: last accepted seq, 01 marker
// RQ6: byte 1: next seq, 11 marker
// RQ7: state 00h right after storing entry
// RQ8: state 01h on missing or wrong seq
// RQ9: state 02h when queue has nothing new
// RQ10: state 03h when queue is full
// RQ11: state ORed 80h while end-marked entry queued
// RQ12: byte 3 always shows queued count; queued_count shows the fifo count one clock late
// RQ13: entry is four bytes: state, seq, time
// RQ14: bits 7..4 drive channels 0..3
// RQ15: seq must be previous plus one
// RQ16: host marks last entry with bit 6
// RQ17: entries after end-marked entry are ignored
// RQ18: free 32-bit microsecond ticker, wrapping
// RQ19: time field matches ticker low word
// RQ20: fault lights module fault indicator
// RQ21: execute in order at matching time

module tos_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } tos_fifo_state_t;

  tos_fifo_state_t r;
  tos_fifo_state_t next_r;
  logic            push;
  logic            pop;

  assign in_ready  = (r.cnt != CW'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rd];
  assign count     = r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = in_data;
      next_r.wr        = (r.wr == AW'(DEPTH-1)) ? '0 : AW'(r.wr + 1'b1);
    end
    if (pop) begin
      next_r.rd = (r.rd == AW'(DEPTH-1)) ? '0 : AW'(r.rd + 1'b1);
    end
    next_r.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

module tos_scheduler #(
  parameter int MAX_ENTRIES = tos_pkg::ENTRIES_LARGE,
  parameter int DEPTH       = tos_pkg::FIFO_DEPTH
) (
  input  wire logic                                    clk,
  input  wire logic                                    reset_n,
  input  wire logic                                    cfg_large,
  input  wire logic                                    area_strobe,
  input  wire logic [MAX_ENTRIES*tos_pkg::ENTRY_W-1:0] area_data,
  input  wire logic                                    overload_fault,
  output logic [7:0]                                   last_accepted_seq,
  output logic [7:0]                                   upcoming_seq,
  output logic [7:0]                                   queue_state,
  output logic [7:0]                                   queued_count,
  output logic [tos_pkg::CHANNELS-1:0]                 digital_out,
  output logic                                         module_fault_led
);
  localparam int IW = $clog2(MAX_ENTRIES);
  localparam int CW = $clog2(DEPTH+1);
  localparam int EW = tos_pkg::ENTRY_W;
  localparam int SW = tos_pkg::SEQ_W;

  typedef enum logic [0:0] {SC_IDLE, SC_SCAN} tos_scan_t;

  typedef struct packed {
    tos_scan_t                          st;
    logic [IW-1:0]                      idx;
    logic [IW-1:0]                      last_idx;
    logic [MAX_ENTRIES-1:0][EW-1:0]     img;
    logic [SW-1:0]                      last;
    logic [1:0]                         code;
    logic [CW-1:0]                      hi;
    logic [tos_pkg::TICKER_W-1:0]       ticker;
    logic [tos_pkg::PRE_W-1:0]          pre;
    logic [tos_pkg::CHANNELS-1:0]       dout;
    logic                               fault;
    logic [7:0]                         last_o;
    logic [7:0]                         next_o;
    logic [7:0]                         state_o;
    logic [7:0]                         count_o;
  } tos_sched_state_t;

  tos_sched_state_t r;
  tos_sched_state_t next_r;

  logic [EW-1:0]     cur;
  logic [SW-1:0]     cur_seq;
  logic              cur_end;
  logic [SW-1:0]     expected;
  logic              seq_ok;
  logic              fifo_push;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [EW-1:0]     head;
  logic [CW-1:0]     fifo_count;
  logic              time_hit;

  // current image entry and its fields
  assign cur      = r.img[r.idx];                                         // [RQ13]
  assign cur_seq  = cur[tos_pkg::SEQ_LSB +: SW];
  assign cur_end  = cur[tos_pkg::SEQ_LSB + tos_pkg::SEQ_END_BIT];
  assign expected = SW'(r.last + 1'b1);
  assign seq_ok   = (cur_seq == expected);                                // [RQ15]
  assign fifo_push = (r.st == SC_SCAN) && seq_ok && fifo_in_ready;        // [RQ3]
  // execute on the first clock of the matching microsecond
  assign time_hit = (r.pre == '0) &&
                    (r.ticker[tos_pkg::TIME_W-1:0] == head[tos_pkg::TIME_LSB +: tos_pkg::TIME_W]); // [RQ19]
  assign fifo_pop = fifo_out_valid && time_hit;                           // [RQ21]

  tos_fifo #(
    .WIDTH (EW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (cur),                                                     // [RQ1]
    .out_valid (fifo_out_valid),
    .out_ready (time_hit),
    .out_data  (head),
    .count     (fifo_count)
  );

  always_comb begin
    next_r = r;
    // microsecond ticker, wraps naturally
    if (r.pre == tos_pkg::PRE_W'(tos_pkg::US_CYCLES - 1)) begin
      next_r.pre    = '0;
      next_r.ticker = r.ticker + 1'b1;                                    // [RQ18]
    end else begin
      next_r.pre = tos_pkg::PRE_W'(r.pre + 1'b1);
    end
    // take a new process image
    if (r.st == SC_IDLE) begin
      if (area_strobe) begin
        next_r.st       = SC_SCAN;
        next_r.idx      = '0;
        next_r.img      = area_data;
        next_r.last_idx = cfg_large ? IW'(tos_pkg::ENTRIES_LARGE - 1)
                                    : IW'(tos_pkg::ENTRIES_SMALL - 1);   // [RQ2]
      end
    end else begin
      if (seq_ok && !fifo_in_ready) begin
        next_r.code = tos_pkg::QS_FULL;                                   // [RQ10]
        next_r.st   = SC_IDLE;                                            // [RQ3]
      end else begin
        if (seq_ok) begin
          next_r.last = cur_seq;
          next_r.code = tos_pkg::QS_OK;                                   // [RQ7]
        end else if (cur_seq != r.last) begin
          next_r.code = tos_pkg::QS_NO_FOLLOW;                            // [RQ8]
        end
        if (cur_end || r.idx == r.last_idx) begin
          next_r.st = SC_IDLE;                                            // [RQ17]
        end else begin
          next_r.idx = IW'(r.idx + 1'b1);
        end
      end
    end
    // execute the head entry
    if (fifo_pop) begin
      for (int k = 0; k < tos_pkg::CHANNELS; k++) begin
        next_r.dout[k] = head[tos_pkg::STATE_LSB + 7 - k];                // [RQ14]
      end
      if (fifo_count == CW'(1) && !fifo_push) begin
        next_r.code = tos_pkg::QS_EMPTY;                                  // [RQ9]
      end
    end
    // end-marked entries inside the queue
    next_r.hi = CW'(r.hi + CW'(fifo_push && cur_end)
                    - CW'(fifo_pop && head[tos_pkg::SEQ_LSB + tos_pkg::SEQ_END_BIT]));
    next_r.fault   = overload_fault;                                      // [RQ20]
    next_r.last_o  = {tos_pkg::LAST_MARK, next_r.last};                   // [RQ5]
    next_r.next_o  = {tos_pkg::NEXT_MARK,
                      fifo_out_valid ? head[tos_pkg::SEQ_LSB +: SW] : expected}; // [RQ6]
    next_r.state_o = {next_r.hi != '0, 5'h00, next_r.code};               // [RQ11]
    next_r.count_o = 8'(fifo_count);                                      // [RQ12]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r         <= '0;
      r.st      <= SC_IDLE;
      r.last    <= tos_pkg::SEQ_RESET;
      r.code    <= tos_pkg::QS_EMPTY;
      r.last_o  <= {tos_pkg::LAST_MARK, tos_pkg::SEQ_RESET};
      r.next_o  <= {tos_pkg::NEXT_MARK, 6'h01};
      r.state_o <= {tos_pkg::QS_PAD, tos_pkg::QS_EMPTY};
    end else begin
      r <= next_r;
    end
  end

  assign last_accepted_seq = r.last_o;
  assign upcoming_seq      = r.next_o;
  assign queue_state       = r.state_o;
  assign queued_count      = r.count_o;
  assign digital_out       = r.dout;
  assign module_fault_led  = r.fault;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_push_end;
    fifo_push && cur_end;
  endsequence

  sequence s_refused;
    (r.st == SC_SCAN) && seq_ok && !fifo_in_ready;
  endsequence

  property p_refuse;
    !fifo_in_ready |-> !fifo_push;
  endproperty
  a_refuse: assert property (p_refuse) else $error("entry pushed into full queue"); // [RQ3]

  property p_full_code;
    s_refused |=> queue_state[1:0] == tos_pkg::QS_FULL;
  endproperty
  a_full_code: assert property (p_full_code) else $error("full queue not reported"); // [RQ10]

  property p_last_mark;
    ##1 last_accepted_seq[7:6] == 2'h1;
  endproperty
  a_last_mark: assert property (p_last_mark) else $error("last seq marker wrong"); // [RQ5]

  property p_next_mark;
    ##1 upcoming_seq[7:6] == 2'h3;
  endproperty
  a_next_mark: assert property (p_next_mark) else $error("next seq marker wrong"); // [RQ6]

  property p_ok_code;
    fifo_push |=> queue_state[1:0] == 2'h0 && last_accepted_seq[5:0] == $past(cur_seq);
  endproperty
  a_ok_code: assert property (p_ok_code) else $error("accepted entry not reported"); // [RQ7]

  property p_end_flag;
    s_push_end |=> queue_state[7];
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end-marked entry flag missing"); // [RQ11]

  property p_stop_scan;
    s_push_end |=> r.st == SC_IDLE;
  endproperty
  a_stop_scan: assert property (p_stop_scan) else $error("scan continued past end mark"); // [RQ17]

  property p_count;
    ##1 queued_count == 8'($past(fifo_count));
  endproperty
  a_count: assert property (p_count) else $error("queued count wrong"); // [RQ12]

  property p_ticker;
    r.pre == tos_pkg::PRE_W'(tos_pkg::US_CYCLES - 1) |=> r.ticker == $past(r.ticker) + 32'h1;
  endproperty
  a_ticker: assert property (p_ticker) else $error("ticker did not advance"); // [RQ18]

  property p_apply;
    fifo_pop |=> digital_out == {$past(head[4]), $past(head[5]), $past(head[6]), $past(head[7])};
  endproperty
  a_apply: assert property (p_apply) else $error("outputs not applied from entry"); // [RQ14]

  property p_exec_time;
    fifo_pop |-> r.ticker[15:0] == head[31:16] && r.pre == '0;
  endproperty
  a_exec_time: assert property (p_exec_time) else $error("entry executed at wrong time"); // [RQ21]

  property p_fault;
    overload_fault |=> module_fault_led;
  endproperty
  a_fault: assert property (p_fault) else $error("fault indicator not lit"); // [RQ20]

  sequence s_bad_seq;
    (r.st == SC_SCAN) && !seq_ok && (cur_seq != r.last) && !fifo_pop;
  endsequence

  sequence s_last_pop;
    fifo_pop && (fifo_count == CW'(1)) && !fifo_push;
  endsequence

  property p_end_stop;
    (r.st == SC_SCAN) && cur_end |=> r.st == SC_IDLE;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("scan continued past end-marked slot"); // [RQ17]

  property p_bad_code;
    s_bad_seq |=> queue_state[1:0] == 2'h1;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad sequence not reported"); // [RQ8]

  property p_empty_code;
    s_last_pop |=> (queue_state[1:0] == 2'h2) ##1 (queued_count == 8'h00);
  endproperty
  a_empty_code: assert property (p_empty_code) else $error("empty queue not reported"); // [RQ9]

  property p_cap;
    queued_count <= 8'(DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("queue count above depth"); // [RQ3]

  property p_next_idle;
    !fifo_out_valid |=> upcoming_seq[5:0] == 6'($past(r.last) + 1'b1);
  endproperty
  a_next_idle: assert property (p_next_idle) else $error("next seq wrong on empty queue"); // [RQ6]

  property p_next_head;
    fifo_out_valid |=> upcoming_seq[5:0] == $past(head[13:8]);
  endproperty
  a_next_head: assert property (p_next_head) else $error("next seq not head entry"); // [RQ6]

  property p_last_hold;
    !fifo_push |=> $stable(last_accepted_seq);
  endproperty
  a_last_hold: assert property (p_last_hold) else $error("last seq changed without push"); // [RQ5]

  property p_seq_step;
    fifo_push |=> last_accepted_seq[5:0] == 6'($past(last_accepted_seq[5:0]) + 1'b1);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("accepted seq not previous plus one"); // [RQ15]

  property p_state_pad;
    queue_state[6:2] == 5'h00;
  endproperty
  a_state_pad: assert property (p_state_pad) else $error("queue state pad bits set"); // [RQ11]

  property p_flag_clear;
    fifo_pop && head[14] && (r.hi == CW'(1)) && !(fifo_push && cur_end) |=> !queue_state[7];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("end-marked flag stuck"); // [RQ11]

  property p_fault_off;
    !overload_fault |=> !module_fault_led;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault indicator lit without fault"); // [RQ20]

  property p_out_hold;
    !fifo_pop |=> $stable(digital_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs changed without execution"); // [RQ21]
endmodule

// [bench/tos_host_model.sv]
`timescale 1ns/100ps
module tos_host_model (
  input  wire logic                                               clk,
  output logic                                                    area_strobe,
  output logic [tos_pkg::ENTRIES_LARGE*tos_pkg::ENTRY_W-1:0]      area_data
);
  initial begin
    area_strobe = 1'b0;
    area_data   = '0;
  end

  // channel 0 goes to state bit 7, low nibble zero
  function automatic logic [31:0] mk(input logic [3:0] ch, input logic [6:0] seq, input logic [15:0] t);
    mk = {t, 1'b0, seq, ch[0], ch[1], ch[2], ch[3], 4'h0};
  endfunction

  task automatic send(input logic [tos_pkg::ENTRIES_LARGE*tos_pkg::ENTRY_W-1:0] img);
    @(posedge clk);
    area_strobe <= 1'b1;
    area_data   <= img;
    @(posedge clk);
    area_strobe <= 1'b0;
    area_data   <= ~img;
    // wait 20 clocks before any further write, no status read
    repeat (20) @(posedge clk);
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic         clk;
  logic         reset_n;
  logic         cfg_large;
  logic         overload_fault;
  logic         area_strobe;
  logic [479:0] area_data;
  logic [479:0] img;
  logic [7:0]   last_accepted_seq;
  logic [7:0]   upcoming_seq;
  logic [7:0]   queue_state;
  logic [7:0]   queued_count;
  logic [3:0]   digital_out;
  logic         module_fault_led;
  logic [15:0]  t0;
  int           fail_count;
  int           compares;
  int           cyc;

  tos_host_model u_host (.clk(clk), .area_strobe(area_strobe), .area_data(area_data));

  tos_scheduler u_dut (
    .clk               (clk),
    .reset_n           (reset_n),
    .cfg_large         (cfg_large),
    .area_strobe       (area_strobe),
    .area_data         (area_data),
    .overload_fault    (overload_fault),
    .last_accepted_seq (last_accepted_seq),
    .upcoming_seq      (upcoming_seq),
    .queue_state       (queue_state),
    .queued_count      (queued_count),
    .digital_out       (digital_out),
    .module_fault_led  (module_fault_led)
  );

  always #10 clk = ~clk;

  always @(posedge clk) cyc <= reset_n ? cyc + 1 : 0;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic put(input logic [479:0] v);
    u_host.send(v);
    #1;
  endtask

  task automatic wait_count(input logic [7:0] n);
    for (int i = 0; i < 3000 && queued_count !== n; i++) begin
      @(posedge clk);
      #1;
    end
    chk("queued_count wait", n, queued_count);
    if (queued_count !== n) end_sim();
  endtask

  task automatic test_reset();
    chk("last_accepted_seq", 8'h40, last_accepted_seq);
    chk("upcoming_seq", 8'hc1, upcoming_seq);
    chk("queue_state", 8'h02, queue_state);
    chk("queued_count", 8'h00, queued_count);
    chk("digital_out", 8'h00, {4'h0, digital_out});
    $display("test reset done");
  endtask

  task automatic test_fault();
    @(posedge clk);
    overload_fault <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("module_fault_led on", 8'h01, {7'h0, module_fault_led});
    @(posedge clk);
    overload_fault <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("module_fault_led off", 8'h00, {7'h0, module_fault_led});
    $display("test fault done");
  endtask

  task automatic test_exec();
    t0 = 16'(cyc / 50 + 12);
    img = '0;
    img[31:0]   = u_host.mk(4'b0101, 7'h01, t0);
    img[63:32]  = u_host.mk(4'b1010, 7'h02, t0 + 16'h3);
    img[95:64]  = u_host.mk(4'b1111, 7'h43, t0 + 16'h6);
    img[127:96] = u_host.mk(4'b0011, 7'h04, t0 + 16'h9);
    put(img);
    chk("last_accepted_seq", 8'h43, last_accepted_seq);
    chk("queue_state", 8'h80, queue_state);
    chk("queued_count", 8'h03, queued_count);
    chk("upcoming_seq", 8'hc1, upcoming_seq);
    chk("digital_out idle", 8'h00, {4'h0, digital_out});
    wait_count(8'h02);
    chk("digital_out first", 8'h05, {4'h0, digital_out});
    chk("upcoming_seq", 8'hc2, upcoming_seq);
    wait_count(8'h01);
    chk("digital_out second", 8'h0a, {4'h0, digital_out});
    wait_count(8'h00);
    chk("digital_out third", 8'h0f, {4'h0, digital_out});
    chk("queue_state", 8'h02, queue_state);
    chk("upcoming_seq", 8'hc4, upcoming_seq);
    $display("test exec done");
  endtask

  task automatic test_bad_seq();
    img = '0;
    img[31:0]    = u_host.mk(4'hf, 7'h05, 16'h0);
    img[191:160] = u_host.mk(4'hf, 7'h44, 16'h0);
    put(img);
    chk("queue_state", 8'h01, queue_state);
    chk("queued_count", 8'h00, queued_count);
    chk("last_accepted_seq", 8'h43, last_accepted_seq);
    $display("test bad seq done");
  endtask

  task automatic test_full();
    t0 = 16'(cyc / 50 + 1500);
    img = '0;
    for (int k = 0; k < 15; k++) img[k*32 +: 32] = u_host.mk(4'(k), 7'(k + 4), t0);
    @(posedge clk);
    cfg_large <= 1'b1;
    put(img);
    chk("queue_state", 8'h00, queue_state);
    chk("queued_count", 8'h0f, queued_count);
    chk("last_accepted_seq", 8'h52, last_accepted_seq);
    img = '0;
    img[31:0]  = u_host.mk(4'h1, 7'h13, t0);
    img[63:32] = u_host.mk(4'h2, 7'h14, t0);
    @(posedge clk);
    cfg_large <= 1'b0;
    put(img);
    chk("queue_state", 8'h03, queue_state);
    chk("queued_count", 8'h10, queued_count);
    chk("last_accepted_seq", 8'h53, last_accepted_seq);
    chk("upcoming_seq", 8'hc4, upcoming_seq);
    $display("test full done");
  endtask

  initial begin
    clk            = 1'b0;
    reset_n        = 1'b0;
    cfg_large      = 1'b0;
    overload_fault = 1'b0;
    fail_count     = 0;
    compares       = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_fault();
    test_exec();
    test_bad_seq();
    test_full();
    end_sim();
  end
endmodule
